// file: timer_match_pkg.sv
// Constants shared by the three-channel timer match/capture flag block.
// Assumes a 20 MHz APB clock and byte addressing on a 20-bit address.
package timer_match_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int NUM_CH = 3;
	localparam int CNT_W = 16;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] TIMER_MATCH_STATUS_A_ADDR = 20'hFFF64;
	localparam logic [ADDR_W-1:0] MATCH_CTRL_ADDR = 20'hFFF80;
	localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 20'hFFF84;
	localparam logic [ADDR_W-1:0] EVENT_ENABLE_ADDR = 20'hFFF88;
	localparam logic [ADDR_W-1:0] EVENT_CLEAR_ADDR = 20'hFFF8C;

	// Field positions of the match status register.
	localparam int FLAG_LSB = 0;
	localparam int ENABLE_LSB = 4;
	// Bits 7 and 3 are unused and always read as one.
	localparam logic [7:0] STATUS_A_FIXED_ONES = 8'h88;
	localparam logic [7:0] STATUS_A_RESET = 8'h88;

	// Field positions of the control register.
	localparam int CAPTURE_MODE_LSB = 0;
	localparam int PHASE_COUNT_BIT = 4;
	localparam logic [NUM_CH-1:0] CAPTURE_MODE_RESET = 3'h0;
	localparam logic PHASE_COUNT_RESET = 1'b0;
	localparam logic [NUM_CH-1:0] ENABLE_RESET = 3'h0;

endpackage : timer_match_pkg

// file: match_flag_cell.sv
// One channel's match/capture flag with its read-then-write-zero clear.
// Assumes all strobes are single-cycle pulses on pclk.
`timescale 1ns/100ps
module match_flag_cell
	import timer_match_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events
	input wire logic set_ev,
	input wire logic dma_clr,
	// Register access
	input wire logic rd_arm,
	input wire logic wr_stb,
	input wire logic wr_bit,
	// State
	output logic flag
);

	typedef struct packed {
		logic flag;
		logic armed;
	} cell_state_t;

	cell_state_t s_q;
	cell_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (rd_arm) begin
			// Only a flag that is one in the cycle rd_arm is high may later be cleared by a zero write.
			s_d.armed = s_q.flag; // see R10
		end
		if (wr_stb) begin
			if (!wr_bit && s_q.armed) begin
				s_d.flag = 1'b0; // see R3
			end
			s_d.armed = 1'b0; // see R6
		end
		if (dma_clr) begin
			s_d.flag = 1'b0; // see R4
			s_d.armed = 1'b0;
		end
		// A new event wins over any clear in the same cycle.
		if (set_ev) begin
			s_d.flag = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0; // see R7
		end else begin
			s_q <= s_d;
		end
	end

	assign flag = s_q.flag;

	a_clear_after_read: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		(wr_stb && !wr_bit && s_q.armed && !set_ev) |=> !flag)
		else $error("armed flag not cleared by zero write");

	a_unread_survives: assert property (@(posedge pclk) disable iff (!presetn) // see R10
		(flag && !s_q.armed && !rd_arm && !dma_clr) |=> flag)
		else $error("flag cleared without a prior read");

	a_dma_clears: assert property (@(posedge pclk) disable iff (!presetn) // see R4
		(dma_clr && !set_ev) |=> !flag)
		else $error("dma activation did not clear flag");

	a_write_no_set: assert property (@(posedge pclk) disable iff (!presetn) // see R6
		(!flag && !set_ev) |=> !flag)
		else $error("flag set without an event");

	a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // see R1
		set_ev |=> flag)
		else $error("event lost against clear");

endmodule : match_flag_cell

// file: event_irq.sv
// Sticky event status, enable mask and write-one-to-clear for one interrupt line.
// Assumes event and strobe inputs are single-cycle pulses on pclk.
`timescale 1ns/100ps
module event_irq #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Events and register writes
	input wire logic [WIDTH-1:0] events,
	input wire logic enable_wr,
	input wire logic clear_wr,
	input wire logic [WIDTH-1:0] wdata,
	// Register view and interrupt
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] enable,
	output logic irq
);

	typedef struct packed {
		logic [WIDTH-1:0] status;
		logic [WIDTH-1:0] enable;
		logic irq;
	} irq_state_t;

	irq_state_t s_q;
	irq_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (enable_wr) begin
			s_d.enable = wdata;
		end
		// Events are OR-ed in after the clear so that none is lost.
		s_d.status = (clear_wr ? (s_q.status & ~wdata) : s_q.status) | events;
		s_d.irq = |(s_d.status & s_d.enable);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign status = s_q.status;
	assign enable = s_q.enable;
	assign irq = s_q.irq;

endmodule : event_irq

// file: timer_match_flag_status.sv
// Match/capture flags, per-channel interrupt enables and the channel-2
// phase-count select for a three-channel 16-bit timer, behind an APB slave.
// Assumes counters, general registers, capture strobes and DMA activation
// strobes all come from logic clocked by pclk.
//
// Overview of operation
// R1: Compare mode: counter equals register A sets flag.
// R2: Capture mode: capture into register A sets flag.
// R3: Read flag as one, write zero clears.
// R4: DMA activation by channel request clears flag.
// R5: Channel request only when its enable is one.
// R6: Writing one never sets a flag.
// R7: Flags and enables are zero after reset.
// R8: Each channel has its own flag and enable.
// R9: Channel-2 select: zero normal, one phase counting.
// R10: Flag set after the read survives clearing.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module timer_match_flag_status
	import timer_match_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Channel 0
	input wire logic [CNT_W-1:0] counter_ch0,
	input wire logic [CNT_W-1:0] general_reg_a_ch0,
	input wire logic capture_ch0,
	input wire logic dma_ack_ch0,
	// Channel 1
	input wire logic [CNT_W-1:0] counter_ch1,
	input wire logic [CNT_W-1:0] general_reg_a_ch1,
	input wire logic capture_ch1,
	input wire logic dma_ack_ch1,
	// Channel 2
	input wire logic [CNT_W-1:0] counter_ch2,
	input wire logic [CNT_W-1:0] general_reg_a_ch2,
	input wire logic capture_ch2,
	input wire logic dma_ack_ch2,
	// Requests and mode
	output logic match_irq_ch0,
	output logic match_irq_ch1,
	output logic match_irq_ch2,
	output logic irq,
	output logic phase_count_ch2
);

	typedef struct packed {
		logic [NUM_CH-1:0] cap_mode;
		logic phase;
		logic [NUM_CH-1:0] en;
		logic [NUM_CH-1:0] eq;
		logic [NUM_CH-1:0] irq_ch;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic slverr;
	} match_state_t;

	match_state_t s_q;
	match_state_t s_d;

	logic [CNT_W-1:0] cnt [NUM_CH];
	logic [CNT_W-1:0] gra [NUM_CH];
	logic [NUM_CH-1:0] capture;
	logic [NUM_CH-1:0] dma_ack;
	logic [NUM_CH-1:0] eq_now;
	logic [NUM_CH-1:0] set_ev;
	logic [NUM_CH-1:0] flags;
	logic [NUM_CH-1:0] ev_status;
	logic [NUM_CH-1:0] ev_enable;

	logic xfer;
	logic wr;
	logic rd;
	logic hit_status_a;
	logic hit_ctrl;
	logic hit_ev_status;
	logic hit_ev_enable;
	logic hit_ev_clear;

	assign cnt[0] = counter_ch0;
	assign cnt[1] = counter_ch1;
	assign cnt[2] = counter_ch2;
	assign gra[0] = general_reg_a_ch0;
	assign gra[1] = general_reg_a_ch1;
	assign gra[2] = general_reg_a_ch2;
	assign capture = {capture_ch2, capture_ch1, capture_ch0};
	assign dma_ack = {dma_ack_ch2, dma_ack_ch1, dma_ack_ch0};

	// The access phase completes on the edge where pready is high.
	assign xfer = psel && penable && s_q.ready;
	assign wr = xfer && pwrite;
	assign rd = xfer && !pwrite;

	assign hit_status_a = paddr[ADDR_W-1:2] == TIMER_MATCH_STATUS_A_ADDR[ADDR_W-1:2];
	assign hit_ctrl = paddr[ADDR_W-1:2] == MATCH_CTRL_ADDR[ADDR_W-1:2];
	assign hit_ev_status = paddr[ADDR_W-1:2] == EVENT_STATUS_ADDR[ADDR_W-1:2];
	assign hit_ev_enable = paddr[ADDR_W-1:2] == EVENT_ENABLE_ADDR[ADDR_W-1:2];
	assign hit_ev_clear = paddr[ADDR_W-1:2] == EVENT_CLEAR_ADDR[ADDR_W-1:2];

	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			assign eq_now[i] = cnt[i] == gra[i];
			// Compare sets once as equality arises; a counter parked on the
			// compare value would otherwise re-set the flag after every clear.
			assign set_ev[i] = s_q.cap_mode[i] ? capture[i] // see R2
				: (eq_now[i] && !s_q.eq[i]); // see R1
			match_flag_cell u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set_ev(set_ev[i]), // see R8
				.dma_clr(dma_ack[i]), // see R4
				.rd_arm(rd && hit_status_a), // see R10
				.wr_stb(wr && hit_status_a), // see R3
				.wr_bit(pwdata[FLAG_LSB + i]), // see R6
				.flag(flags[i])
			);
		end
	endgenerate

	event_irq #(
		.WIDTH(NUM_CH)
	) u_event_irq (
		.pclk(pclk),
		.presetn(presetn),
		.events(set_ev),
		.enable_wr(wr && hit_ev_enable),
		.clear_wr(wr && hit_ev_clear),
		.wdata(pwdata[NUM_CH-1:0]),
		.status(ev_status),
		.enable(ev_enable),
		.irq(irq)
	);

	always_comb begin
		s_d = s_q;
		s_d.eq = eq_now;
		s_d.irq_ch = flags & s_q.en; // see R5
		// Zero-wait slave: ready is raised for the access after every setup.
		s_d.ready = psel && !penable;
		s_d.slverr = 1'b0;
		s_d.rdata = '0;
		if (psel && !penable) begin
			if (hit_status_a) begin
				s_d.rdata[7:0] = STATUS_A_FIXED_ONES
					| ({5'h00, flags} << FLAG_LSB)
					| ({5'h00, s_q.en} << ENABLE_LSB);
			end else if (hit_ctrl) begin
				s_d.rdata[CAPTURE_MODE_LSB +: NUM_CH] = s_q.cap_mode;
				s_d.rdata[PHASE_COUNT_BIT] = s_q.phase;
			end else if (hit_ev_status) begin
				s_d.rdata[NUM_CH-1:0] = ev_status;
			end else if (hit_ev_enable) begin
				s_d.rdata[NUM_CH-1:0] = ev_enable;
			end else if (!hit_ev_clear) begin
				s_d.slverr = 1'b1;
			end
		end
		if (wr && hit_status_a) begin
			s_d.en = pwdata[ENABLE_LSB +: NUM_CH]; // see R8
		end
		if (wr && hit_ctrl) begin
			s_d.cap_mode = pwdata[CAPTURE_MODE_LSB +: NUM_CH];
			s_d.phase = pwdata[PHASE_COUNT_BIT]; // see R9
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.cap_mode <= CAPTURE_MODE_RESET;
			s_q.phase <= PHASE_COUNT_RESET; // see R9
			s_q.en <= ENABLE_RESET; // see R7
			s_q.eq <= '0;
			s_q.irq_ch <= '0;
			s_q.rdata <= '0;
			s_q.ready <= 1'b0;
			s_q.slverr <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.ready;
	assign pslverr = s_q.slverr;
	assign match_irq_ch0 = s_q.irq_ch[0];
	assign match_irq_ch1 = s_q.irq_ch[1];
	assign match_irq_ch2 = s_q.irq_ch[2];
	assign phase_count_ch2 = s_q.phase;

	a_compare_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // see R1
		(!s_q.cap_mode[0] && counter_ch0 == general_reg_a_ch0 && !s_q.eq[0]) |=> flags[0])
		else $error("compare match did not set channel 0 flag");

	a_capture_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // see R2
		(s_q.cap_mode[1] && capture_ch1) |=> flags[1])
		else $error("capture did not set channel 1 flag");

	a_request_gated: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		match_irq_ch2 == $past(flags[2] && s_q.en[2]))
		else $error("channel 2 request not gated by its enable");

	a_reset_values: assert property (@(posedge pclk) // see R7
		!presetn |-> (flags == 3'h0 && s_q.en == 3'h0 && !phase_count_ch2))
		else $error("flags or enables not zero in reset");

	a_channel_isolated: assert property (@(posedge pclk) disable iff (!presetn) // see R8
		(!flags[1] && !set_ev[1]) |=> !flags[1])
		else $error("channel 1 flag set by another channel");

	a_phase_select: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		(wr && hit_ctrl) |=> phase_count_ch2 == $past(pwdata[PHASE_COUNT_BIT]))
		else $error("phase count select not written");

	a_read_then_clear: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		(rd && hit_status_a && flags[0]) ##1 !psel ##1 (psel && !penable)
		##1 (wr && hit_status_a && !pwdata[FLAG_LSB] && !set_ev[0]) |=> !flags[0])
		else $error("read then zero write did not clear");

	a_apb_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> (pready ##1 !pready))
		else $error("pready not a single access cycle");

	c_compare_match: cover property (@(posedge pclk) disable iff (!presetn)
		set_ev[0] && !s_q.cap_mode[0]);
	c_capture: cover property (@(posedge pclk) disable iff (!presetn)
		set_ev[1] && s_q.cap_mode[1]);
	c_dma_clear: cover property (@(posedge pclk) disable iff (!presetn)
		flags[2] && dma_ack_ch2 ##1 !flags[2]);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule : timer_match_flag_status

// file: timer_match_flag_status_tb_top.sv
// Self-checking bench for the timer match/capture flag block.
// Assumes zero-wait APB answers and single-cycle event strobes on pclk.
`timescale 1ns/100ps
module timer_match_flag_status_tb_top
	import timer_match_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, phase_count_ch2;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rv;
	logic [CNT_W-1:0] cnt [3];
	logic [CNT_W-1:0] gra [3];
	logic [2:0] cap, dack, mirq;
	logic ev;
	int num_errors, checked, cyc;
	localparam logic [ADDR_W-1:0] ST = TIMER_MATCH_STATUS_A_ADDR;

	timer_match_flag_status u_timer_match_flag_status (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.counter_ch0(cnt[0]), .general_reg_a_ch0(gra[0]), .capture_ch0(cap[0]),
		.dma_ack_ch0(dack[0]), .counter_ch1(cnt[1]), .general_reg_a_ch1(gra[1]),
		.capture_ch1(cap[1]), .dma_ack_ch1(dack[1]), .counter_ch2(cnt[2]),
		.general_reg_a_ch2(gra[2]), .capture_ch2(cap[2]), .dma_ack_ch2(dack[2]),
		.match_irq_ch0(mirq[0]), .match_irq_ch1(mirq[1]), .match_irq_ch2(mirq[2]),
		.irq(irq), .phase_count_ch2(phase_count_ch2)
	);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Holds the request until pready is seen high, then idles one cycle before returning.
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the bench timeout ends a wait for a slave that never answers.
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk("write error", 32'h0, {31'h0, ev});
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("read error", 32'h0, {31'h0, ev});
		chk("read data", exp, rv);
	endtask : rd

	// Kind 0 is a compare equality, 1 a capture strobe, 2 a DMA activation.
	task automatic pulse(input int ch, input int k);
		case (k)
			0: cnt[ch] <= gra[ch];
			1: cap[ch] <= 1'b1;
			default: dack[ch] <= 1'b1;
		endcase
		@(posedge pclk);
		cnt[ch] <= 16'h0000;
		cap[ch] <= 1'b0;
		dack[ch] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : pulse

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = '0;
		pwdata = '0;
		cnt = '{16'h0000, 16'h0000, 16'h0000};
		gra = '{16'h1234, 16'h5678, 16'h9ABC};
		cap = 3'h0;
		dack = 3'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ST, 32'h88);
		rd(MATCH_CTRL_ADDR, 32'h0);
		chk("phase count", 32'h0, {31'h0, phase_count_ch2});
		$display("test reset done");
		for (int c = 0; c < 3; c++) begin
			pulse(c, 0);
			rd(ST, 32'h88 | (32'h1 << c));
			chk("masked request", 32'h0, {29'h0, mirq});
			wr(ST, 32'h88);
			rd(ST, 32'h88);
		end
		$display("test compare done");
		pulse(0, 0);
		wr(ST, 32'h8F);
		rd(ST, 32'h89);
		pulse(1, 0);
		wr(ST, 32'h88);
		rd(ST, 32'h8A);
		wr(ST, 32'h88);
		rd(ST, 32'h88);
		$display("test clear done");
		pulse(1, 0);
		wr(ST, 32'hA8);
		repeat (2) @(posedge pclk);
		chk("request ch1", 32'h2, {29'h0, mirq});
		pulse(2, 0);
		chk("request ch2 off", 32'h2, {29'h0, mirq});
		pulse(1, 2);
		chk("request after dma", 32'h0, {29'h0, mirq});
		rd(ST, 32'hAC);
		wr(ST, 32'h88);
		rd(ST, 32'h88);
		pulse(0, 0);
		pulse(2, 0);
		wr(ST, 32'hD8);
		repeat (2) @(posedge pclk);
		chk("request ch0 ch2", 32'h5, {29'h0, mirq});
		rd(ST, 32'hDD);
		wr(ST, 32'h88);
		rd(ST, 32'h88);
		$display("test enable done");
		wr(MATCH_CTRL_ADDR, 32'h7);
		for (int c = 0; c < 3; c++) begin
			pulse(c, 0);
			rd(ST, 32'h88);
			pulse(c, 1);
			rd(ST, 32'h88 | (32'h1 << c));
			pulse(c, 2);
			rd(ST, 32'h88);
		end
		wr(MATCH_CTRL_ADDR, 32'h10);
		chk("phase count", 32'h1, {31'h0, phase_count_ch2});
		rd(MATCH_CTRL_ADDR, 32'h10);
		wr(MATCH_CTRL_ADDR, 32'h0);
		$display("test capture done");
		wr(EVENT_CLEAR_ADDR, 32'h7);
		rd(EVENT_STATUS_ADDR, 32'h0);
		wr(EVENT_ENABLE_ADDR, 32'h7);
		rd(EVENT_ENABLE_ADDR, 32'h7);
		pulse(0, 0);
		chk("event irq", 32'h1, {31'h0, irq});
		rd(EVENT_STATUS_ADDR, 32'h1);
		wr(EVENT_ENABLE_ADDR, 32'h0);
		chk("event irq masked", 32'h0, {31'h0, irq});
		wr(EVENT_ENABLE_ADDR, 32'h7);
		wr(EVENT_CLEAR_ADDR, 32'h1);
		chk("event irq cleared", 32'h0, {31'h0, irq});
		rd(EVENT_STATUS_ADDR, 32'h0);
		rd(EVENT_CLEAR_ADDR, 32'h0);
		apb(1'b0, 20'h00010, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, ev});
		chk("unmapped data", 32'h0, rv);
		$display("test events done");
		finish_test();
	end
endmodule : timer_match_flag_status_tb_top
